/* rtl/external_interrupt_pin_unit.sv */
// External interrupt pin unit: request latch, status and control, pull-up and break control.
//
// Contract
// RULE1: Vector fetch clears the request latch.
// RULE2: Writing one to acknowledge clears the latch.
// RULE3: Acknowledge bit reads zero, reset clears it.
// RULE4: Falling edge after acknowledge sets latch again.
// RULE5: Unmasked pending request interrupts, vector FFFA/FFFB.
// RULE6: Level mode: pending until acknowledged and pin high.
// RULE7: Reset clears latch and sensitivity select.
// RULE8: Edge mode: falling edges set, acknowledge clears.
// RULE9: Pending flag reads request, ignoring the mask.
// RULE10: Mask bit one blocks interrupts; reset clears.
// RULE11: Select one: edge and level; zero: edge.
// RULE12: Pull-up connected unless disable bit is one.
// RULE13: Break clear enabled: acknowledge clears, stays cleared.
// RULE14: Break clear disabled: acknowledge ignored during break.
// RULE15: Pin level available for branch instructions.
// RULE16: Level mode software masks inside the handler.
// RULE17: Synchronise pin before detecting falling edges.
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "eip_params.svh"
module external_interrupt_pin_unit
    import eip_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic irq_pin_n,
    input wire logic vector_fetch,
    input wire logic break_state,
    output logic irq_to_cpu,
    output logic pin_level,
    output logic pullup_enable,
    output logic [15:0] vector_hi_addr,
    output logic [15:0] vector_lo_addr
);

    // ************************************************************
    // Bus port and pin synchroniser.
    // ************************************************************

    // Register index of the current address phase.
    logic [7:0] rd_index;
    // Accepted read address phase.
    logic rd_take;
    // Byte presented for the current read.
    logic [7:0] rd_byte;
    // Data-phase write strobe.
    reg_write_t wr;
    // Pin level after two flip-flops.
    logic pin_sync;

    ahb_reg_port u_bus
    (
        .clk(clk),
        .arst_n(arst_n),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hready(hready),
        .hwdata(hwdata),
        .rd_byte(rd_byte),
        .rd_index(rd_index),
        .rd_take(rd_take),
        .wr(wr),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp)
    );

    // The pin idles high under its pull-up, so the synchroniser resets high.
    pin_synchroniser #(.RESET_VALUE(1'b1)) u_pin_sync
    (
        .clk(clk),
        .arst_n(arst_n),
        .async_in(irq_pin_n),
        .sync_out(pin_sync)
    ); // RULE17

    // ************************************************************
    // Registers and decode.
    // ************************************************************

    // Request latch set by falling edges.
    logic latch_reg;
    logic latch_next;
    // Interrupt mask; one blocks requests toward the processor.
    logic mask_reg;
    // Sensitivity select; one adds low-level triggering.
    logic mode_reg;
    // Configuration byte holding the pull-up disable bit.
    logic [7:0] pin_cfg_reg;
    // Break flag control byte holding the break clear enable bit.
    logic [7:0] break_ctrl_reg;
    // Synchronised pin level one cycle earlier, for edge detection.
    logic pin_prev_reg;
    // Marks that the last read came from the status and control register.
    logic rd_status_reg;
    // Edge detector warm-up; bit 2 rises once the previous level is a real pin sample.
    logic [2:0] warm_reg;

    // Decoded strobes and events.
    logic wr_status;
    logic wr_pin_cfg;
    logic wr_break_ctrl;
    logic sw_ack_write;
    logic sw_ack;
    logic clear_req;
    logic falling;
    logic pin_low;
    logic pending;
    logic break_clear_en;
    logic [7:0] status_byte;

    assign wr_status = wr.en && (wr.index == `EIP_IDX_STATUS);
    assign wr_pin_cfg = wr.en && (wr.index == `EIP_IDX_PIN_CFG);
    assign wr_break_ctrl = wr.en && (wr.index == `EIP_IDX_BREAK_CTRL);
    assign break_clear_en = break_ctrl_reg[`EIP_BIT_BREAK_CLEAR];

    // A one in the acknowledge position is the software clear request.
    assign sw_ack_write = wr_status && wr.data[`EIP_BIT_ACK]; // RULE2
    // During break the clear only passes when the break clear enable bit is set.
    assign sw_ack = sw_ack_write && (!break_state || break_clear_en); // RULE13 RULE14
    // Vector fetch and software acknowledge act as one interrupt acknowledge.
    assign clear_req = vector_fetch || sw_ack; // RULE1 RULE2

    // Edges are taken from the synchronised level only, so each edge is seen once.
    assign pin_low = !pin_sync;
    // The stages reset high, so a pin held low through reset would look like a fall; the warm-up hides it.
    assign falling = warm_reg[2] && pin_prev_reg && !pin_sync; // RULE7 RULE17

    // The set wins over a clear in the same cycle, so a new edge is never lost.
    assign latch_next = falling || (latch_reg && !clear_req); // RULE4 RULE8

    // Level mode keeps the request alive while the pin stays low, whatever the acknowledge order.
    assign pending = latch_reg || (mode_reg && pin_low); // RULE6 RULE11

    // Status byte: acknowledge always reads zero, pending ignores the mask.
    assign status_byte = {4'h0, pending, 1'b0, mask_reg, mode_reg}; // RULE3 RULE9

    // Read selection; unmapped indices read zero.
    assign rd_byte = (rd_index == `EIP_IDX_STATUS) ? status_byte :
                     (rd_index == `EIP_IDX_PIN_CFG) ? pin_cfg_reg :
                     (rd_index == `EIP_IDX_BREAK_CTRL) ? break_ctrl_reg : 8'h00;

    // ************************************************************
    // Request latch and control state.
    // ************************************************************

    // Reset clears the latch and the mode, dropping a request even with the pin held low.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            latch_reg <= 1'b0; // RULE7
            mode_reg <= 1'b0; // RULE7
            mask_reg <= 1'b0; // RULE10
            pin_prev_reg <= 1'b1;
            warm_reg <= 3'h0;
        end
        else
        begin
            latch_reg <= latch_next;
            pin_prev_reg <= pin_sync;
            warm_reg <= {warm_reg[1:0], 1'b1};
            if (wr_status)
            begin
                mode_reg <= wr.data[`EIP_BIT_MODE]; // RULE11
                mask_reg <= wr.data[`EIP_BIT_MASK]; // RULE10
            end
        end
    end

    // Configuration and break control bytes are plain read/write storage.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_cfg_reg <= `EIP_RST_PIN_CFG;
            break_ctrl_reg <= `EIP_RST_BREAK_CTRL;
            rd_status_reg <= 1'b0;
        end
        else
        begin
            if (wr_pin_cfg)
            begin
                pin_cfg_reg <= wr.data;
            end
            if (wr_break_ctrl)
            begin
                break_ctrl_reg <= wr.data;
            end
            if (rd_take)
            begin
                rd_status_reg <= (rd_index == `EIP_IDX_STATUS);
            end
        end
    end

    // ************************************************************
    // Outputs toward the processor and the pad.
    // ************************************************************

    // All outputs are registered, so each trails its cause by one clock.
    // The handler should set the mask in level mode, or a held-low pin re-enters at once.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irq_to_cpu <= 1'b0;
            pin_level <= 1'b1;
            pullup_enable <= 1'b1;
            vector_hi_addr <= `EIP_VECTOR_HI_ADDR;
            vector_lo_addr <= `EIP_VECTOR_LO_ADDR;
        end
        else
        begin
            irq_to_cpu <= pending && !mask_reg; // RULE5 RULE10
            pin_level <= pin_sync; // RULE15
            pullup_enable <= !pin_cfg_reg[`EIP_BIT_PULLUP_DISABLE]; // RULE12
            vector_hi_addr <= `EIP_VECTOR_HI_ADDR; // RULE5
            vector_lo_addr <= `EIP_VECTOR_LO_ADDR; // RULE5
        end
    end

    // ************************************************************
    // Checks.
    // ************************************************************

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    // A pending acknowledge with no new edge.
    sequence s_ack_no_edge;
        clear_req && !falling;
    endsequence

    property p_fetch_clears;
        vector_fetch && !falling |=> !latch_reg;
    endproperty
    a_fetch_clears: assert property (p_fetch_clears) else $error("vector fetch left latch set"); // RULE1

    property p_sw_ack_clears;
        sw_ack_write && !break_state && !falling |=> !latch_reg;
    endproperty
    a_sw_ack_clears: assert property (p_sw_ack_clears) else $error("software ack left latch set"); // RULE2

    property p_ack_reads_zero;
        rd_take ##1 rd_status_reg |-> !hrdata[`EIP_BIT_ACK];
    endproperty
    a_ack_reads_zero: assert property (p_ack_reads_zero) else $error("ack bit read as one"); // RULE3

    property p_edge_sets;
        falling |=> latch_reg ##1 (latch_reg || $past(clear_req));
    endproperty
    a_edge_sets: assert property (p_edge_sets) else $error("falling edge not latched"); // RULE4

    property p_cpu_request;
        (pending && !mask_reg) ##1 !(pending && !mask_reg) |-> irq_to_cpu ##1 !irq_to_cpu;
    endproperty
    a_cpu_request: assert property (p_cpu_request) else $error("cpu request does not follow pending"); // RULE5

    property p_level_holds;
        mode_reg && pin_low && !wr_status ##0 s_ack_no_edge
            |=> (pin_sync || pending) ##1 (pin_sync || $past(pin_sync) || irq_to_cpu || mask_reg);
    endproperty
    a_level_holds: assert property (p_level_holds) else $error("level request dropped with pin low"); // RULE6

    property p_edge_mode_clears;
        !mode_reg && !wr_status ##0 s_ack_no_edge |=> !pending;
    endproperty
    a_edge_mode_clears: assert property (p_edge_mode_clears) else $error("edge mode request not cleared"); // RULE8

    property p_pending_unmasked;
        mask_reg && latch_reg && rd_take && (rd_index == `EIP_IDX_STATUS) |=> hrdata[`EIP_BIT_PENDING];
    endproperty
    a_pending_unmasked: assert property (p_pending_unmasked) else $error("pending flag hidden by mask"); // RULE9

    property p_mask_blocks;
        mask_reg && !wr_status |=> !irq_to_cpu;
    endproperty
    a_mask_blocks: assert property (p_mask_blocks) else $error("masked request reached cpu"); // RULE10

    property p_pullup;
        wr_pin_cfg |=> ##1 (pullup_enable == !$past(wr.data[`EIP_BIT_PULLUP_DISABLE], 2));
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up does not follow disable bit"); // RULE12

    property p_break_protects;
        break_state && !break_clear_en && sw_ack_write && latch_reg && !vector_fetch |=> latch_reg;
    endproperty
    a_break_protects: assert property (p_break_protects) else $error("ack cleared latch during break"); // RULE14

    property p_break_clears;
        break_state && break_clear_en && sw_ack_write && !falling |=> !latch_reg;
    endproperty
    a_break_clears: assert property (p_break_clears) else $error("enabled break ack did not clear"); // RULE13

    property p_pin_level;
        ##1 1'b1 |-> pin_level == $past(pin_sync);
    endproperty
    a_pin_level: assert property (p_pin_level) else $error("pin level output stale"); // RULE15

endmodule

/* rtl/eip_params.svh */
// Constants of the external interrupt pin unit: offsets, bit positions, reset values.
`ifndef EIP_PARAMS_SVH
`define EIP_PARAMS_SVH

// ************************************************************
// Register indices; the byte address is four times the index.
// ************************************************************
`define EIP_IDX_BREAK_CTRL 8'h1c
`define EIP_IDX_STATUS 8'h1d
`define EIP_IDX_PIN_CFG 8'h1e

// ************************************************************
// Field positions.
// ************************************************************
`define EIP_BIT_MODE 0
`define EIP_BIT_MASK 1
`define EIP_BIT_ACK 2
`define EIP_BIT_PENDING 3
`define EIP_BIT_PULLUP_DISABLE 7
`define EIP_BIT_BREAK_CLEAR 7

// ************************************************************
// Reset values and fixed vector locations.
// ************************************************************
`define EIP_RST_PIN_CFG 8'h00
`define EIP_RST_BREAK_CTRL 8'h00
`define EIP_VECTOR_HI_ADDR 16'hfffa
`define EIP_VECTOR_LO_ADDR 16'hfffb

`endif

/* rtl/eip_pkg.sv */
// Types shared by the external interrupt pin unit and its bus port.
package eip_pkg;

    // One register write, presented in the data phase of an accepted write.
    typedef struct packed
    {
        logic en;
        logic [7:0] index;
        logic [7:0] data;
    } reg_write_t;

endpackage

/* rtl/pin_synchroniser.sv */
// Two-stage synchroniser for one asynchronous pin.
`timescale 1ns/1ps
module pin_synchroniser
#(
    parameter logic RESET_VALUE = 1'b1
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic async_in,
    output logic sync_out
);

    // First stage; only the second stage reads it, so metastability stays contained.
    logic meta_reg;

    // Both stages reset to the idle level of the pin.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_reg <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule

/* rtl/ahb_reg_port.sv */
// AHB-Lite slave port that turns bus transfers into register reads and write strobes.
`timescale 1ns/1ps
module ahb_reg_port
    import eip_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [7:0] rd_byte,
    output logic [7:0] rd_index,
    output logic rd_take,
    output reg_write_t wr,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp
);

    // ************************************************************
    // Address phase decode.
    // ************************************************************

    // Only word-aligned addresses in the low kilobyte map to registers.
    logic addr_ok;
    // A transfer is accepted when selected, NONSEQ or SEQ, and the bus is ready.
    logic take;
    // Write address phase held over into the data phase.
    logic wr_pend_reg;
    logic [7:0] wr_index_reg;

    assign addr_ok = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
    assign take = hsel && htrans[1] && hready;
    assign rd_index = addr_ok ? haddr[9:2] : 8'hff;
    assign rd_take = take && !hwrite;

    // Write strobe stands for the single data-phase cycle; unmapped writes carry index ff.
    assign wr.en = wr_pend_reg;
    assign wr.index = wr_index_reg;
    assign wr.data = hwdata[7:0];

    // Capture the write address; read data is latched at the address edge, so zero wait states.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_pend_reg <= 1'b0;
            wr_index_reg <= 8'h00;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            wr_pend_reg <= take && hwrite;
            wr_index_reg <= rd_index;
            if (rd_take)
            begin
                hrdata <= {24'h000000, rd_byte};
            end
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

endmodule

/* bench/irq_source_model.sv */
// Behavioural model of the external source that drives the active-low interrupt pin.
`timescale 1ns/1ps
module irq_source_model
(
    input wire logic clk,
    input wire logic driven,
    input wire logic hold_low,
    input wire logic pullup_enable,
    output logic irq_pin_n
);
    // Stand-in for a floating line: it moves every cycle, so no stale level is ever trusted.
    logic float_reg = 1'b0;

    // The floating pattern runs regardless of whether anyone looks at it.
    always @(posedge clk)
        float_reg <= ~float_reg;

    // Driven, the source sets the level; released, only the pull-up holds the pin high.
    assign irq_pin_n = driven ? ~hold_low : (pullup_enable ? 1'b1 : float_reg);
endmodule

/* bench/external_interrupt_pin_unit_tb.sv */
// Self-checking testbench of the external interrupt pin unit against a cycle model.
`timescale 1ns/1ps
`include "eip_params.svh"
`define CHK(got, exp) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) \
        begin \
            n_fail++; \
            $display("[ERR] %0t got %h exp %h", $time, got, exp); \
        end \
    end
module external_interrupt_pin_unit_tb;
    logic clk, arst_n, hsel, hwrite, vf, brk_st, hold_low, driven;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata;
    logic hreadyout, hresp, pin_n, irq, lvl, pu;
    logic [15:0] vhi, vlo;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;
    // Model state: three sync stages, latch, control bits and the pending bus write.
    logic s1, s2, s3, latch, mode, mask, irq_exp, dp_wr;
    logic [7:0] cfg2, bctl, dp_idx, exp_rd;
    // Edges count only once two real pin samples have passed the stages after reset.
    int warm;
    wire fall = (warm > 2) & s3 & ~s2;
    wire pend = latch | (mode & ~s2);
    wire ack_now = dp_wr & (dp_idx == `EIP_IDX_STATUS) & hwdata[`EIP_BIT_ACK];

    // ****************
    // Design and partner.
    // ****************
    external_interrupt_pin_unit DUT (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irq_pin_n(pin_n), .vector_fetch(vf), .break_state(brk_st),
        .irq_to_cpu(irq), .pin_level(lvl), .pullup_enable(pu), .vector_hi_addr(vhi), .vector_lo_addr(vlo));
    irq_source_model src (.clk(clk), .driven(driven), .hold_low(hold_low), .pullup_enable(pu), .irq_pin_n(pin_n));

    // Expected read byte of a register index, from the model's present state.
    function automatic logic [7:0] rd_val(input logic [7:0] i);
        case (i)
            `EIP_IDX_STATUS: rd_val = {4'h0, pend, 1'b0, mask, mode};
            `EIP_IDX_PIN_CFG: rd_val = cfg2;
            `EIP_IDX_BREAK_CTRL: rd_val = bctl;
            default: rd_val = 8'h00;
        endcase
    endfunction

    // ****************
    // Cycle model of the unit.
    // ****************
    always @(posedge clk or negedge arst_n)
        if (!arst_n)
        begin
            {s1, s2, s3, latch, mode, mask, irq_exp, dp_wr} <= 8'he0;
            warm <= 0;
            cfg2 <= 8'h00;
            bctl <= 8'h00;
        end
        else
        begin
            s1 <= pin_n;
            s2 <= s1;
            s3 <= s2;
            if (warm < 3)
                warm <= warm + 1;
            dp_wr <= hsel & htrans[1] & hwrite;
            dp_idx <= haddr[9:2];
            if (hsel & htrans[1] & !hwrite)
                exp_rd <= rd_val(haddr[9:2]);
            irq_exp <= pend & ~mask;
            // A new edge beats a clear in the same cycle.
            if (fall)
                latch <= 1'b1;
            else if (vf | (ack_now & (~brk_st | bctl[`EIP_BIT_BREAK_CLEAR])))
                latch <= 1'b0;
            if (dp_wr && dp_idx == `EIP_IDX_STATUS)
            begin
                mode <= hwdata[`EIP_BIT_MODE];
                mask <= hwdata[`EIP_BIT_MASK];
            end
            if (dp_wr && dp_idx == `EIP_IDX_PIN_CFG)
                cfg2 <= hwdata[7:0];
            if (dp_wr && dp_idx == `EIP_IDX_BREAK_CTRL)
                bctl <= hwdata[7:0];
        end

    // Outputs are compared mid-cycle, well away from the launching edge.
    always @(negedge clk)
        if (arst_n)
        begin
            `CHK(irq, irq_exp)
            // Pin level is only compared once the pin has been still long enough to pass the sync.
            if (s1 == s2 && s2 == s3 && s1 == pin_n)
                `CHK(lvl, s2)
        end

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Ends the run with the verdict.
    task automatic summarize;
        if (n_fail == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Hang guard: the whole sequence needs far fewer cycles than this.
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_fail++;
            summarize();
        end
    end

    // One single AHB-Lite word transfer; reads are compared with the model.
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {22'h0, idx, 2'b00};
        @(posedge clk);
        while (hreadyout !== 1'b1)
            @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        @(posedge clk);
        while (hreadyout !== 1'b1)
            @(posedge clk);
        `CHK(hresp, 1'b0)
        if (!wr)
            `CHK(hrdata, {24'h0, exp_rd})
    endtask

    // Sets the pin drive and lets some cycles pass.
    task automatic pin(input logic low, input int n);
        hold_low <= low;
        repeat (n) @(posedge clk);
    endtask

    // A one-cycle vector fetch strobe.
    task automatic fetch;
        vf <= 1'b1;
        @(posedge clk);
        vf <= 1'b0;
    endtask

    initial
    begin
        {arst_n, hsel, hwrite, vf, brk_st, hold_low} = 6'h00;
        {htrans, haddr, hwdata, driven} = 67'h1;
        void'($urandom(32'hc801));
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        `CHK(vhi, `EIP_VECTOR_HI_ADDR)
        `CHK(vlo, `EIP_VECTOR_LO_ADDR)
        `CHK(pu, 1'b1)
        for (int i = 28; i < 32; i++)
            bus(1'b0, 8'(i), 8'h00);
        // Edge mode: set by a fall, cleared by a fetch while the pin is still low.
        pin(1'b1, 6);
        bus(1'b0, `EIP_IDX_STATUS, 8'h00);
        fetch();
        pin(1'b1, 6);
        bus(1'b0, `EIP_IDX_STATUS, 8'h00);
        // Masked request still shows as pending; ack clears, a later fall relatches.
        pin(1'b0, 4);
        bus(1'b1, `EIP_IDX_STATUS, 8'h02);
        pin(1'b1, 6);
        bus(1'b0, `EIP_IDX_STATUS, 8'h00);
        bus(1'b1, `EIP_IDX_STATUS, 8'h06);
        bus(1'b0, `EIP_IDX_STATUS, 8'h00);
        pin(1'b0, 1);
        pin(1'b1, 6);
        bus(1'b0, `EIP_IDX_STATUS, 8'h00);
        // Break state: ack ignored unless break clear is enabled, then it sticks.
        brk_st <= 1'b1;
        bus(1'b1, `EIP_IDX_STATUS, 8'h06);
        bus(1'b0, `EIP_IDX_STATUS, 8'h00);
        bus(1'b1, `EIP_IDX_BREAK_CTRL, 8'h80);
        bus(1'b1, `EIP_IDX_STATUS, 8'h06);
        brk_st <= 1'b0;
        pin(1'b1, 2);
        bus(1'b0, `EIP_IDX_STATUS, 8'h00);
        // Level mode, both orders of ack and pin release; the handler masks in the first order only.
        bus(1'b1, `EIP_IDX_STATUS, 8'h01);
        bus(1'b1, `EIP_IDX_STATUS, 8'h07);
        bus(1'b0, `EIP_IDX_STATUS, 8'h00);
        pin(1'b0, 6);
        bus(1'b0, `EIP_IDX_STATUS, 8'h00);
        pin(1'b1, 6);
        pin(1'b0, 6);
        bus(1'b1, `EIP_IDX_STATUS, 8'h05);
        bus(1'b0, `EIP_IDX_STATUS, 8'h00);
        // A second reset with the pin held low; no request may come back while it stays low.
        pin(1'b1, 6);
        arst_n <= 1'b0;
        pin(1'b1, 2);
        arst_n <= 1'b1;
        @(posedge clk);
        bus(1'b0, `EIP_IDX_STATUS, 8'h00);
        pin(1'b1, 6);
        bus(1'b0, `EIP_IDX_STATUS, 8'h00);
        pin(1'b0, 4);
        // Pull-up off with the source released, then back on.
        bus(1'b1, `EIP_IDX_PIN_CFG, 8'h80);
        pin(1'b0, 2);
        `CHK(pu, 1'b0)
        driven <= 1'b0;
        bus(1'b1, `EIP_IDX_PIN_CFG, 8'h00);
        pin(1'b0, 2);
        `CHK(pu, 1'b1)
        driven <= 1'b1;
        // Random mix of pin activity, fetches, break and register writes.
        repeat (80)
        begin
            hold_low <= 1'($urandom);
            vf <= ($urandom % 4) == 0;
            brk_st <= 1'($urandom);
            @(posedge clk);
            vf <= 1'b0;
            bus(1'b1, 8'h1c + 8'($urandom % 3), 8'($urandom));
            bus(1'b0, 8'h1c + 8'($urandom % 4), 8'h00);
        end
        summarize();
    end
endmodule
